// ===== dmsc_channel.sv
// Dual mode serial channel: asynchronous and clocked shift modes
// Assumes all inputs synchronous to aclk; tick inputs are one-cycle pulses
`include "dmsc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module dmsc_channel (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Clock sources
  input wire logic baud_tick,
  input wire logic timer_match_trigger,
  // Serial pins
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  input wire logic shift_clock_in,
  output logic shift_clock_out,
  output logic shift_clock_oe,
  input wire logic clear_to_send_in,
  // Events
  output logic rx_done_irq,
  output logic tx_empty_irq
);
  import dmsc_pkg::*;

  dmsc_state_type s_q;
  dmsc_state_type s_d;
  logic [1:0] fmt;
  logic uart_mode;
  logic shift_clock_direction;
  logic pe;
  logic base_tick;
  logic tx_bit_clock;
  logic pin_rise;
  logic pin_fall;
  logic io_edge;
  logic [3:0] nbits;
  logic maj;
  logic [8:0] word;
  logic cts_hold;

  function automatic logic par(input logic even, input logic [7:0] d);
    par = even ? ^d : ~^d;
  endfunction : par

  assign fmt = s_q.mode[3:2];
  assign uart_mode = (fmt != `DMSC_FMT_IO);
  assign shift_clock_direction = s_q.ctrl[`DMSC_CTRL_IOC];
  assign pe = s_q.ctrl[`DMSC_CTRL_PE] & (fmt != `DMSC_FMT_9BIT);
  assign pin_rise = shift_clock_in & ~s_q.sclk_prev;
  assign pin_fall = ~shift_clock_in & s_q.sclk_prev;
  assign cts_hold = s_q.mode[`DMSC_MODE_HSK] & clear_to_send_in;

  // Base clock of the asynchronous mode
  always_comb begin
    unique case (s_q.mode[1:0])
      `DMSC_SRC_TIMER: base_tick = timer_match_trigger;
      `DMSC_SRC_BAUD: base_tick = baud_tick;
      `DMSC_SRC_SYS: base_tick = 1'b1;
      `DMSC_SRC_PIN: base_tick = pin_rise;
    endcase
  end

  // Transmit bit clock once every sixteen base ticks
  assign tx_bit_clock = base_tick & (s_q.tx_cnt == `DMSC_TICKS_LAST);

  // Shift clock edge, internal (halved divider) or pin
  always_comb begin
    if (!shift_clock_direction) begin
      io_edge = baud_tick & s_q.io_active &
        (s_q.ctrl[`DMSC_CTRL_EDGE] ? s_q.sclk_out : ~s_q.sclk_out);
    end else begin
      io_edge = s_q.io_active &
        (s_q.ctrl[`DMSC_CTRL_EDGE] ? pin_fall : pin_rise);
    end
  end

  // Data bits per frame, parity included
  always_comb begin
    unique case (fmt)
      `DMSC_FMT_7BIT: nbits = pe ? 4'd8 : 4'd7;
      `DMSC_FMT_8BIT: nbits = pe ? 4'd9 : 4'd8;
      `DMSC_FMT_9BIT: nbits = 4'd9;
      `DMSC_FMT_IO: nbits = `DMSC_IO_BITS;
    endcase
  end

  assign maj = (s_q.rx_samp[1] & s_q.rx_samp[0]) |
    (s_q.rx_samp[1] & serial_in_pin) |
    (s_q.rx_samp[0] & serial_in_pin);

  always_comb begin
    word = s_q.rx_sh;
    word[s_q.rx_idx] = maj;
  end

  always_comb begin
    s_d = s_q;
    s_d.rx_irq = 1'b0;
    s_d.tx_irq = 1'b0;
    s_d.sclk_prev = shift_clock_in;

    // Read channel: side effects clear before hardware sets
    if (s_q.rvalid && rready) begin
      s_d.rvalid = 1'b0;
    end
    if (arvalid && !s_q.rvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = `DMSC_RESP_OKAY;
      s_d.rdata = 32'h0000_0000;
      unique case (araddr)
        `DMSC_ADDR_DATA: begin
          s_d.rdata[7:0] = s_q.rx_buf;
          s_d.rx_full = 1'b0;
        end
        `DMSC_ADDR_MODE: s_d.rdata[7:0] = s_q.mode;
        `DMSC_ADDR_CTRL: begin
          s_d.rdata[7:0] = s_q.ctrl;
          s_d.ctrl[`DMSC_CTRL_OVR] = 1'b0;
          s_d.ctrl[`DMSC_CTRL_PARITY_ERROR_FLAG] = 1'b0;
          s_d.ctrl[`DMSC_CTRL_FRAMING_ERROR_FLAG] = 1'b0;
        end
        `DMSC_ADDR_STAT: begin
          s_d.rdata[3:0] = {s_q.tx_active | s_q.io_active, s_q.tx_full,
            s_q.rx_state != RX_IDLE, s_q.rx_full};
        end
        default: s_d.rresp = `DMSC_RESP_SLVERR;
      endcase
    end

    // Asynchronous transmitter
    if (base_tick) begin
      s_d.tx_cnt = s_q.tx_cnt + 4'd1;
    end
    if (uart_mode && tx_bit_clock) begin
      if (!s_q.tx_active || s_q.tx_left == 4'd0) begin
        s_d.tx_active = 1'b0;
        s_d.serial_out = 1'b1;
        if (s_q.tx_full && !cts_hold) begin
          s_d.tx_active = 1'b1;
          s_d.serial_out = 1'b0;
          s_d.tx_sh = {2'b11, s_q.mode[`DMSC_MODE_NINTH], s_q.tx_buf};
          if (nbits == 4'd7) begin
            s_d.tx_sh[8:7] = 2'b11;
          end else if (nbits == 4'd8) begin
            s_d.tx_sh[8] = 1'b1;
          end
          s_d.tx_left = nbits + 4'd1;
        end
      end else begin
        s_d.serial_out = s_q.tx_sh[0];
        s_d.tx_sh = {1'b1, s_q.tx_sh[10:1]};
        s_d.tx_left = s_q.tx_left - 4'd1;
        if (s_q.tx_left == 4'd1) begin
          s_d.tx_full = 1'b0;
          s_d.tx_irq = 1'b1;
        end
      end
    end

    // Asynchronous receiver
    if (!uart_mode || !s_q.mode[`DMSC_MODE_RXE]) begin
      s_d.rx_state = RX_IDLE;
    end else if (base_tick) begin
      s_d.rx_cnt = s_q.rx_cnt + 4'd1;
      if (s_q.rx_cnt == `DMSC_SAMPLE_A || s_q.rx_cnt == `DMSC_SAMPLE_B) begin
        s_d.rx_samp = {s_q.rx_samp[0], serial_in_pin};
      end
      unique case (s_q.rx_state)
        RX_IDLE: begin
          s_d.rx_cnt = 4'd1;
          if (!serial_in_pin) begin
            s_d.rx_state = RX_START;
          end
        end
        RX_START: begin
          if (s_q.rx_cnt == `DMSC_SAMPLE_C) begin
            s_d.rx_state = maj ? RX_IDLE : RX_DATA;
            s_d.rx_idx = 4'd0;
            s_d.rx_sh = 9'h000;
          end
        end
        RX_DATA: begin
          if (s_q.rx_cnt == `DMSC_SAMPLE_C) begin
            s_d.rx_sh = word;
            s_d.rx_idx = s_q.rx_idx + 4'd1;
            if (s_q.rx_idx == nbits - 4'd1) begin
              s_d.rx_state = RX_STOP;
              if (s_q.rx_full) begin
                s_d.ctrl[`DMSC_CTRL_OVR] = 1'b1;
              end else begin
                s_d.rx_full = 1'b1;
                s_d.rx_buf = word[7:0];
                if (nbits == 4'd9) begin
                  s_d.ctrl[`DMSC_CTRL_NINTH] = word[8];
                end
                if (pe && fmt == `DMSC_FMT_7BIT &&
                    par(s_q.ctrl[`DMSC_CTRL_EVEN], {1'b0, word[6:0]})
                    != word[7]) begin
                  s_d.ctrl[`DMSC_CTRL_PARITY_ERROR_FLAG] = 1'b1;
                end
                if (pe && fmt == `DMSC_FMT_8BIT &&
                    par(s_q.ctrl[`DMSC_CTRL_EVEN], word[7:0]) != word[8]) begin
                  s_d.ctrl[`DMSC_CTRL_PARITY_ERROR_FLAG] = 1'b1;
                end
                s_d.rx_irq = !(fmt == `DMSC_FMT_9BIT &&
                  s_q.mode[`DMSC_MODE_WAKE] && !word[8]);
              end
            end
          end
        end
        RX_STOP: begin
          if (s_q.rx_cnt == `DMSC_SAMPLE_C) begin
            if (!maj) begin
              s_d.ctrl[`DMSC_CTRL_FRAMING_ERROR_FLAG] = 1'b1;
            end
            s_d.rx_state = RX_IDLE;
          end
        end
      endcase
    end

    // Clocked shift mode, eight bits LSB first
    if (!uart_mode) begin
      if (!s_q.io_active) begin
        s_d.sclk_out = 1'b1;
        if (s_q.tx_full || (shift_clock_direction && s_q.mode[`DMSC_MODE_RXE])) begin
          s_d.io_active = 1'b1;
          s_d.io_tx = s_q.tx_full;
          s_d.io_left = `DMSC_IO_BITS;
          s_d.tx_sh = {3'b111, s_q.tx_full ? s_q.tx_buf : 8'hFF};
          s_d.serial_out = s_q.tx_full ? s_q.tx_buf[0] : 1'b1;
        end
      end else begin
        if (!shift_clock_direction && baud_tick) begin
          s_d.sclk_out = ~s_q.sclk_out;
        end
        if (io_edge) begin
          s_d.rx_sh = {serial_in_pin, s_q.rx_sh[8:1]};
          s_d.tx_sh = {1'b1, s_q.tx_sh[10:1]};
          s_d.serial_out = s_q.tx_sh[1];
          s_d.io_left = s_q.io_left - 4'd1;
          if (s_q.io_left == 4'd1) begin
            s_d.io_active = 1'b0;
            s_d.sclk_out = 1'b1;
            s_d.serial_out = 1'b1;
            if (s_q.io_tx) begin
              s_d.tx_full = 1'b0;
              s_d.tx_irq = 1'b1;
            end
            if (s_q.mode[`DMSC_MODE_RXE]) begin
              if (s_q.rx_full) begin
                s_d.ctrl[`DMSC_CTRL_OVR] = 1'b1;
              end else begin
                s_d.rx_full = 1'b1;
                s_d.rx_buf = {serial_in_pin, s_q.rx_sh[8:2]};
                s_d.rx_irq = 1'b1;
              end
            end
          end
        end
      end
    end

    // Write channel: buffer write wins over the empty marking
    if (awvalid && !s_q.aw_have) begin
      s_d.aw_have = 1'b1;
      s_d.aw_addr = awaddr;
    end
    if (wvalid && !s_q.w_have) begin
      s_d.w_have = 1'b1;
      s_d.w_data = wdata[7:0];
      s_d.w_strb0 = wstrb[0];
    end
    if (s_q.bvalid && bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
      s_d.aw_have = 1'b0;
      s_d.w_have = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = `DMSC_RESP_OKAY;
      unique case (s_q.aw_addr)
        `DMSC_ADDR_DATA: begin
          if (s_q.w_strb0) begin
            s_d.tx_buf = s_q.w_data;
            s_d.tx_full = 1'b1;
            if (pe && fmt == `DMSC_FMT_7BIT) begin
              s_d.tx_buf[7] = par(s_q.ctrl[`DMSC_CTRL_EVEN],
                {1'b0, s_q.w_data[6:0]});
            end
            if (pe && fmt == `DMSC_FMT_8BIT) begin
              s_d.mode[`DMSC_MODE_NINTH] =
                par(s_q.ctrl[`DMSC_CTRL_EVEN], s_q.w_data);
            end
          end
        end
        `DMSC_ADDR_MODE: begin
          if (s_q.w_strb0) begin
            s_d.mode = s_q.w_data;
          end
        end
        `DMSC_ADDR_CTRL: begin
          if (s_q.w_strb0) begin
            s_d.ctrl[`DMSC_CTRL_EVEN] = s_q.w_data[`DMSC_CTRL_EVEN];
            s_d.ctrl[`DMSC_CTRL_PE] = s_q.w_data[`DMSC_CTRL_PE];
            s_d.ctrl[`DMSC_CTRL_EDGE] = s_q.w_data[`DMSC_CTRL_EDGE];
            s_d.ctrl[`DMSC_CTRL_IOC] = s_q.w_data[`DMSC_CTRL_IOC];
          end
        end
        `DMSC_ADDR_STAT: s_d.bresp = `DMSC_RESP_OKAY;
        default: s_d.bresp = `DMSC_RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.mode <= `DMSC_MODE_RESET;
      s_q.serial_out <= 1'b1;
      s_q.sclk_out <= 1'b1;
      s_q.sclk_prev <= 1'b1;
      s_q.rx_state <= RX_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs
  assign awready = !s_q.aw_have;
  assign wready = !s_q.w_have;
  assign bvalid = s_q.bvalid;
  assign bresp = s_q.bresp;
  assign arready = !s_q.rvalid;
  assign rvalid = s_q.rvalid;
  assign rdata = s_q.rdata;
  assign rresp = s_q.rresp;
  assign serial_out_pin = s_q.serial_out;
  assign shift_clock_out = s_q.sclk_out;
  assign shift_clock_oe = !uart_mode && !shift_clock_direction;
  assign rx_done_irq = s_q.rx_irq;
  assign tx_empty_irq = s_q.tx_irq;
endmodule : dmsc_channel
`default_nettype wire

// ===== dmsc_defines.svh
// Register offsets, field positions, codes and counts of the serial channel
// Assumes inclusion by name from the package and the channel module
`ifndef DMSC_DEFINES_SVH
`define DMSC_DEFINES_SVH
`define DMSC_ADDR_DATA 8'h00
`define DMSC_ADDR_MODE 8'h04
`define DMSC_ADDR_CTRL 8'h08
`define DMSC_ADDR_STAT 8'h0C
`define DMSC_RESP_OKAY 2'b00
`define DMSC_RESP_SLVERR 2'b10
`define DMSC_MODE_RESET 8'h00
`define DMSC_MODE_NINTH 7
`define DMSC_MODE_HSK 6
`define DMSC_MODE_RXE 5
`define DMSC_MODE_WAKE 4
`define DMSC_CTRL_NINTH 7
`define DMSC_CTRL_EVEN 6
`define DMSC_CTRL_PE 5
`define DMSC_CTRL_OVR 4
`define DMSC_CTRL_PARITY_ERROR_FLAG 3
`define DMSC_CTRL_FRAMING_ERROR_FLAG 2
`define DMSC_CTRL_EDGE 1
`define DMSC_CTRL_IOC 0
`define DMSC_FMT_IO 2'b00
`define DMSC_FMT_7BIT 2'b01
`define DMSC_FMT_8BIT 2'b10
`define DMSC_FMT_9BIT 2'b11
`define DMSC_SRC_TIMER 2'b00
`define DMSC_SRC_BAUD 2'b01
`define DMSC_SRC_SYS 2'b10
`define DMSC_SRC_PIN 2'b11
`define DMSC_TICKS_LAST 4'hF
`define DMSC_SAMPLE_A 4'h7
`define DMSC_SAMPLE_B 4'h8
`define DMSC_SAMPLE_C 4'h9
`define DMSC_IO_BITS 4'h8
`define DMSC_EXT_MIN_UART_CYC 4
`define DMSC_EXT_MIN_IO_CYC 16
`endif

// ===== dmsc_pkg.sv
// Types of the dual mode serial channel
// Assumes the constants header sits in the same folder
`include "dmsc_defines.svh"
package dmsc_pkg;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} dmsc_rx_type;
  typedef struct packed {
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [7:0] w_data;
    logic w_strb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] mode;
    logic [7:0] ctrl;
    logic [7:0] rx_buf;
    logic rx_full;
    logic [7:0] tx_buf;
    logic tx_full;
    logic tx_active;
    logic [10:0] tx_sh;
    logic [3:0] tx_left;
    logic [3:0] tx_cnt;
    logic serial_out;
    dmsc_rx_type rx_state;
    logic [3:0] rx_cnt;
    logic [1:0] rx_samp;
    logic [3:0] rx_idx;
    logic [8:0] rx_sh;
    logic sclk_prev;
    logic sclk_out;
    logic io_active;
    logic io_tx;
    logic [3:0] io_left;
    logic rx_irq;
    logic tx_irq;
  } dmsc_state_type;
endpackage : dmsc_pkg

// ===== dmsc_checker.sv
// Port checks of the serial channel
// Assumes a bind into the channel; one clock, synchronous low reset
`timescale 1ns/1ps
`default_nettype none
module dmsc_checker (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  // Clocking and events
  input wire logic baud_tick,
  input wire logic shift_clock_out,
  input wire logic rx_done_irq,
  input wire logic tx_empty_irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_write_answer: assert property (awvalid && awready && wvalid && wready
    |-> ##[1:3] bvalid) else $error("write answer late");
  a_write_hold: assert property (bvalid && !bready
    |=> bvalid && $stable(bresp)) else $error("write answer dropped");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  a_read_hold: assert property (rvalid && !rready
    |=> rvalid && $stable(rdata)) else $error("read answer dropped");
  a_ar_refuse: assert property (rvalid |-> !arready)
    else $error("read taken while answer pending");
  a_rx_pulse: assert property (rx_done_irq |=> !rx_done_irq)
    else $error("receive event too long");
  a_tx_pulse: assert property (tx_empty_irq |=> !tx_empty_irq)
    else $error("transmit event too long");
  a_sclk_tick: assert property ($changed(shift_clock_out)
    |-> $past(baud_tick)) else $error("shift clock moved without tick");
  c_rx: cover property (rx_done_irq);
  c_tx: cover property (tx_empty_irq);
  c_slverr: cover property (rvalid && rresp == 2'h2);
endmodule : dmsc_checker
`default_nettype wire

// ===== dmsc_peer.sv
// Remote asynchronous sender on the channel's serial input
// Assumes one base tick per aclk, so sixteen cycles per bit
`timescale 1ns/1ps
`default_nettype none
module dmsc_peer (
  // Clock
  input wire logic aclk,
  // Frame request
  input wire logic send_req,
  input wire logic [7:0] tx_byte,
  input wire logic bad_stop,
  // Serial line
  output logic line
);
  logic [7:0] cnt_q;
  logic [9:0] fr_q;
  logic run_q = 1'b0;
  always_ff @(posedge aclk) begin
    if (send_req && !run_q) begin
      run_q <= 1'b1;
      cnt_q <= 8'h00;
      fr_q <= {!bad_stop, tx_byte, 1'b0};
    end else if (run_q) begin
      cnt_q <= cnt_q + 8'h01;
      if (cnt_q[3:0] == 4'hF) fr_q <= {1'b1, fr_q[9:1]};
      if (cnt_q == 8'h9F) run_q <= 1'b0;
    end
  end
  // Idle high outside frames
  assign line = run_q ? fr_q[0] : 1'b1;
endmodule : dmsc_peer
`default_nettype wire

// ===== dmsc_channel_tb.sv
// Bench of the serial channel: bus tasks, peer sender, frame checks
// Assumes the channel, checker and peer compile first
`timescale 1ns/1ps
`default_nettype none
module dmsc_channel_tb;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr, pbyte;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, r, bc;
  logic baud_tick, sin, sout, sclk, cts, rxi, txi, go, pbad, sc_prev;
  logic soe;
  int err_total, num_checks, rxn, txn, lows, rises, k;
  dmsc_channel uut (.aclk, .aresetn, .awvalid, .awready, .awaddr,
    .awprot(3'h0), .wvalid, .wready, .wdata, .wstrb(4'hF), .bvalid,
    .bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0),
    .rvalid, .rready, .rdata, .rresp, .baud_tick,
    .timer_match_trigger(1'b0), .serial_in_pin(sin),
    .serial_out_pin(sout), .shift_clock_in(1'b1),
    .shift_clock_out(sclk), .shift_clock_oe(soe),
    .clear_to_send_in(cts), .rx_done_irq(rxi), .tx_empty_irq(txi));
  dmsc_peer peer (.aclk, .send_req(go), .tx_byte(pbyte),
    .bad_stop(pbad), .line(sin));
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // Baud ticks and event counters
  always @(posedge aclk) begin
    bc <= bc + 2'h1;
    baud_tick <= bc == 2'h3;
    sc_prev <= sclk;
    if (rxi === 1'b1) rxn++;
    if (txi === 1'b1) txn++;
    if (sout === 1'b0) lows++;
    if (sclk === 1'b1 && sc_prev === 1'b0) rises++;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic aw, w;
    @(posedge aclk);
    aw = 1'b1;
    w = 1'b1;
    awaddr <= a;
    wdata <= {24'h00_0000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (aw && awready) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask : rd
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk(d, {24'h00_0000, e});
  endtask : rc
  task automatic snd(input logic [7:0] b, input logic bad);
    @(posedge aclk);
    go <= 1'b1;
    pbyte <= b;
    pbad <= bad;
    @(posedge aclk);
    go <= 1'b0;
    repeat (165) @(posedge aclk);
  endtask : snd
  task automatic txf(input logic [7:0] e);
    for (int i = 0; i < 2000 && sout !== 1'b0; i++) @(posedge aclk);
    repeat (8) @(posedge aclk);
    chk(sout, 1'b0);
    for (int i = 0; i < 9; i++) begin
      repeat (16) @(posedge aclk);
      chk(sout, i < 8 ? e[i] : 1'b1);
    end
  endtask : txf
  task automatic tally_and_finish;
    if (err_total == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    #(20 * 20000);
    err_total++;
    tally_and_finish;
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {go, pbad, cts, baud_tick} = 4'h0;
    {awaddr, araddr, pbyte, wdata, bc} = 58'h0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    chk(soe, 1'b1);
    rc(8'h04, 8'h00);
    rc(8'h08, 8'h00);
    rc(8'h0C, 8'h00);
    rd(8'h10);
    chk(r, 2'h2);
    wr(8'h04, 8'h2A);
    chk(r, 2'h0);
    chk(soe, 1'b0);
    wr(8'h00, 8'hA5);
    txf(8'hA5);
    chk(txn, 8'h01);
    wr(8'h08, 8'h60);
    wr(8'h04, 8'h26);
    wr(8'h00, 8'h07);
    txf(8'h87);
    wr(8'h08, 8'h00);
    wr(8'h04, 8'h2A);
    snd(8'h3C, 1'b0);
    chk(rxn, 8'h01);
    rc(8'h00, 8'h3C);
    snd(8'h5A, 1'b0);
    snd(8'h77, 1'b0);
    chk(rxn, 8'h02);
    rd(8'h08);
    chk(d[4], 1'b1);
    rc(8'h00, 8'h5A);
    snd(8'h11, 1'b1);
    rd(8'h08);
    chk(d[2], 1'b1);
    rc(8'h00, 8'h11);
    wr(8'h08, 8'h60);
    wr(8'h04, 8'h26);
    snd(8'h07, 1'b0);
    rd(8'h08);
    chk(d[3], 1'b1);
    rc(8'h00, 8'h07);
    wr(8'h08, 8'h00);
    wr(8'h04, 8'h6A);
    cts <= 1'b1;
    wr(8'h00, 8'h81);
    lows = 0;
    repeat (300) @(posedge aclk);
    chk(lows, 8'h00);
    cts <= 1'b0;
    txf(8'h81);
    wr(8'h04, 8'h00);
    k = txn;
    rises = 0;
    wr(8'h00, 8'hC3);
    for (int i = 0; i < 500 && txn == k; i++) @(posedge aclk);
    chk(rises, 8'h08);
    tally_and_finish;
  end
endmodule : dmsc_channel_tb
bind dmsc_channel dmsc_checker chk_i (.aclk, .aresetn, .awvalid,
  .awready, .wvalid, .wready, .bvalid, .bready, .bresp, .arvalid,
  .arready, .rvalid, .rready, .rdata, .rresp, .baud_tick,
  .shift_clock_out, .rx_done_irq, .tx_empty_irq);
`default_nettype wire
